//--- hw/ifeb_bank.v
// Interrupt flag and enable bank: five flag words, five enable words, APB slave.
// Assumes source events are one-cycle pulses from logic on clk and that the
// priority fields live elsewhere and arrive as per-source "nonzero" levels.
//
// Summary of operation
// - Low-voltage detect flag sits at bit 8 of flag word four.
// - Flag word four holds CRC at bit 3, UART B error 2, UART A error 1.
// - Unimplemented bits always read zero regardless of writes.
// - A flag reads one after its event, zero until then since last clear.
// - An enable bit of one passes its source request, zero blocks it.
// - All implemented flag and enable bits reset to zero.
// - Implemented flag and enable bits are readable and writable by software.
// - Enable word zero upper byte: ADC, UART A tx/rx, SPI A, timer C.
// - Enable word zero lower byte: timer B, compares, captures, timer A, ext irq A.
// - Enable word one upper byte: UART B tx/rx, ext irq C, timers, compares.
// - Enable word one lower: ext irq B, pin change, comparator, I2C A; bits 8-5 absent.
// - Enable word two: parallel port, compare E, captures E/D/C, SPI B.
// - Enable word three: calendar clock bit 14, I2C B master 2, slave 1.
// - Enable word four: low voltage 8, CRC 3, UART B error 2, UART A error 1.
// - Flag word one holds UART B tx at bit 15, rx at bit 14.
// - A priority field of all zeros disables the source; here it gates only srcRequest, not the summary status or irqOut.
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ns
`include "ifeb_map.vh"

module ifeb_bank #(
   parameter NUM_WORDS = 5,
   parameter ADDR_W    = 12
) (
   input  wire                    clk,
   input  wire                    srst,
   input  wire [ADDR_W-1:0]       paddr,
   input  wire                    psel,
   input  wire                    penable,
   input  wire                    pwrite,
   input  wire [31:0]             pwdata,
   output reg  [31:0]             prdata,
   output wire                    pready,
   output reg                     pslverr,
   input  wire [NUM_WORDS*16-1:0] srcEvent,
   input  wire [NUM_WORDS*16-1:0] prioNonZero,
   output wire [NUM_WORDS*16-1:0] srcRequest,
   output wire                    irqOut
);

   // Source positions as flat indices, word * 16 + bit. Each source keeps one
   // position in both its flag word and its enable word, so one table serves both.
   // Word zero, upper byte.
   localparam SRC_ADC_DONE        = 13;
   localparam SRC_UART_A_TX       = 12;
   localparam SRC_UART_A_RX       = 11;
   localparam SRC_SPI_A_EVENT     = 10;
   localparam SRC_SPI_A_FAULT     = 9;
   localparam SRC_TIMER_C         = 8;
   // Word zero, lower byte; bit 4 is absent.
   localparam SRC_TIMER_B         = 7;
   localparam SRC_OUT_CMP_B       = 6;
   localparam SRC_IN_CAP_B        = 5;
   localparam SRC_TIMER_A         = 3;
   localparam SRC_OUT_CMP_A       = 2;
   localparam SRC_IN_CAP_A        = 1;
   localparam SRC_EXT_IRQ_A       = 0;
   // Word one, upper byte; bit 8 is absent.
   localparam SRC_UART_B_TX       = 16 + `IFEB_BIT_UART_B_TX;
   localparam SRC_UART_B_RX       = 16 + `IFEB_BIT_UART_B_RX;
   localparam SRC_EXT_IRQ_C       = 16 + 13;
   localparam SRC_TIMER_E         = 16 + 12;
   localparam SRC_TIMER_D         = 16 + 11;
   localparam SRC_OUT_CMP_D       = 16 + 10;
   localparam SRC_OUT_CMP_C       = 16 + 9;
   // Word one, lower byte; bits 7 to 5 are absent.
   localparam SRC_EXT_IRQ_B       = 16 + 4;
   localparam SRC_PIN_CHANGE      = 16 + 3;
   localparam SRC_COMPARATOR      = 16 + 2;
   localparam SRC_I2C_A_MASTER    = 16 + 1;
   localparam SRC_I2C_A_SLAVE     = 16 + 0;
   // Word two.
   localparam SRC_PAR_MASTER_PORT = 32 + 13;
   localparam SRC_OUT_CMP_E       = 32 + 9;
   localparam SRC_IN_CAP_E        = 32 + 7;
   localparam SRC_IN_CAP_D        = 32 + 6;
   localparam SRC_IN_CAP_C        = 32 + 5;
   localparam SRC_SPI_B_EVENT     = 32 + 1;
   localparam SRC_SPI_B_FAULT     = 32 + 0;
   // Word three.
   localparam SRC_CALENDAR_CLOCK  = 48 + 14;
   localparam SRC_I2C_B_MASTER    = 48 + 2;
   localparam SRC_I2C_B_SLAVE     = 48 + 1;
   // Word four.
   localparam SRC_LOW_VOLTAGE     = 64 + `IFEB_BIT_LOW_VOLTAGE;
   localparam SRC_CRC_GEN         = 64 + `IFEB_BIT_CRC_GEN;
   localparam SRC_UART_B_ERROR    = 64 + `IFEB_BIT_UART_B_ERROR;
   localparam SRC_UART_A_ERROR    = 64 + `IFEB_BIT_UART_A_ERROR;

   // Implemented bits of all five words, built from the table above so that a
   // source moved in the table moves in the write masks and the event masks too.
   localparam [79:0] IMPL_MASK = (80'h1 << SRC_ADC_DONE)
                               | (80'h1 << SRC_UART_A_TX)
                               | (80'h1 << SRC_UART_A_RX)
                               | (80'h1 << SRC_SPI_A_EVENT)
                               | (80'h1 << SRC_SPI_A_FAULT)
                               | (80'h1 << SRC_TIMER_C)
                               | (80'h1 << SRC_TIMER_B)
                               | (80'h1 << SRC_OUT_CMP_B)
                               | (80'h1 << SRC_IN_CAP_B)
                               | (80'h1 << SRC_TIMER_A)
                               | (80'h1 << SRC_OUT_CMP_A)
                               | (80'h1 << SRC_IN_CAP_A)
                               | (80'h1 << SRC_EXT_IRQ_A)
                               | (80'h1 << SRC_UART_B_TX)
                               | (80'h1 << SRC_UART_B_RX)
                               | (80'h1 << SRC_EXT_IRQ_C)
                               | (80'h1 << SRC_TIMER_E)
                               | (80'h1 << SRC_TIMER_D)
                               | (80'h1 << SRC_OUT_CMP_D)
                               | (80'h1 << SRC_OUT_CMP_C)
                               | (80'h1 << SRC_EXT_IRQ_B)
                               | (80'h1 << SRC_PIN_CHANGE)
                               | (80'h1 << SRC_COMPARATOR)
                               | (80'h1 << SRC_I2C_A_MASTER)
                               | (80'h1 << SRC_I2C_A_SLAVE)
                               | (80'h1 << SRC_PAR_MASTER_PORT)
                               | (80'h1 << SRC_OUT_CMP_E)
                               | (80'h1 << SRC_IN_CAP_E)
                               | (80'h1 << SRC_IN_CAP_D)
                               | (80'h1 << SRC_IN_CAP_C)
                               | (80'h1 << SRC_SPI_B_EVENT)
                               | (80'h1 << SRC_SPI_B_FAULT)
                               | (80'h1 << SRC_CALENDAR_CLOCK)
                               | (80'h1 << SRC_I2C_B_MASTER)
                               | (80'h1 << SRC_I2C_B_SLAVE)
                               | (80'h1 << SRC_LOW_VOLTAGE)
                               | (80'h1 << SRC_CRC_GEN)
                               | (80'h1 << SRC_UART_B_ERROR)
                               | (80'h1 << SRC_UART_A_ERROR);

   // Per-word implemented-bit mask; a word beyond the fifth has no sources.
   function [15:0] word_mask;
      input integer idx;
      begin
         case (idx)
            0:       word_mask = IMPL_MASK[15:0];
            1:       word_mask = IMPL_MASK[31:16];
            2:       word_mask = IMPL_MASK[47:32];
            3:       word_mask = IMPL_MASK[63:48];
            4:       word_mask = IMPL_MASK[79:64];
            default: word_mask = 16'h0000;
         endcase
      end
   endfunction

   // Flag and enable words are gathered from the per-word registers below.
   wire [NUM_WORDS*16-1:0] flagVec;
   wire [NUM_WORDS*16-1:0] enVec;
   // Summary interrupt state: one sticky bit and one enable bit per word.
   reg  [NUM_WORDS-1:0]    irqStat_q;
   reg  [NUM_WORDS-1:0]    irqEn_q;
   wire [NUM_WORDS-1:0]    irqStat_d;
   wire [NUM_WORDS-1:0]    irqClrMask;
   wire [NUM_WORDS-1:0]    wordEvent;
   // Address decode and access qualifiers.
   wire [NUM_WORDS-1:0]    selFlag;
   wire [NUM_WORDS-1:0]    selEn;
   wire                    selIrqStat;
   wire                    selIrqClr;
   wire                    selIrqEn;
   wire                    addrHit;
   wire                    accessPhase;
   wire                    wrAccess;
   wire                    irqClrWr;
   wire                    irqEnWr;

   // Zero-wait slave: every access completes in its first access cycle. Holding
   // pready high costs nothing here because every register answers from flops.
   assign pready      = 1'b1;
   assign accessPhase = psel & penable;
   assign wrAccess    = accessPhase & pwrite;

   // Decode of the summary interrupt group; the status word is read-only and a
   // write to it is quietly dropped rather than flagged as an error.
   assign selIrqStat = (paddr == `IFEB_OFF_IRQ_STAT);
   assign selIrqClr  = (paddr == `IFEB_OFF_IRQ_CLR);
   assign selIrqEn   = (paddr == `IFEB_OFF_IRQ_EN);
   assign irqClrWr   = wrAccess & selIrqClr;
   assign irqEnWr    = wrAccess & selIrqEn;

   // Any address that decodes to nothing, misaligned ones included, is an error.
   assign addrHit = (|selFlag) | (|selEn) | selIrqStat | selIrqClr | selIrqEn;

   genvar k;
   generate
      for (k = 0; k < NUM_WORDS; k = k + 1)
      begin : gWord
         localparam [15:0] MASK     = word_mask(k);
         localparam integer FLAG_OFS = `IFEB_OFF_FLAG_BASE + 4 * k;
         localparam integer EN_OFS   = `IFEB_OFF_EN_BASE + 4 * k;
         reg  [15:0] wordFlag_q;
         reg  [15:0] wordEn_q;
         wire [15:0] wordFlag_d;
         wire [15:0] evt;
         wire        flagWr;
         wire        enWr;

         // Word decode; the offsets are cut to the bus width on purpose.
         assign selFlag[k] = (paddr == FLAG_OFS[ADDR_W-1:0]);
         assign selEn[k]   = (paddr == EN_OFS[ADDR_W-1:0]);
         assign flagWr     = wrAccess & selFlag[k];
         assign enWr       = wrAccess & selEn[k];

         // Events on absent bit positions are dropped here, so they can never
         // leak into a flag, the summary status or a request.
         assign evt          = srcEvent[k*16 +: 16] & MASK;
         assign wordEvent[k] = |evt;

         // A new event ORs in after the write, so it is never lost to a clear
         // that software issues in the same cycle. Software may also set flags.
         assign wordFlag_d = (flagWr ? (pwdata[15:0] & MASK) : wordFlag_q) | evt;

         // Flags are sticky; enables are plain software state.
         always @(posedge clk)
         begin
            if (srst)
            begin
               wordFlag_q <= `IFEB_RST_WORD;
               wordEn_q   <= `IFEB_RST_WORD;
            end
            else
            begin
               wordFlag_q <= wordFlag_d;
               if (enWr)
               begin
                  wordEn_q <= pwdata[15:0] & MASK;
               end
            end
         end

         // Each word lands in its own slice of the flat vectors.
         assign flagVec[k*16 +: 16] = wordFlag_q;
         assign enVec[k*16 +: 16]   = wordEn_q;
      end
   endgenerate

   // Each source reaches arbitration only when flagged, enabled and given a priority.
   // The enable does not stop the flag from setting, only from reaching arbitration.
   assign srcRequest = flagVec & enVec & prioNonZero;

   // Summary interrupt next state: clear first, then OR in events, so set wins.
   assign irqClrMask = irqClrWr ? pwdata[NUM_WORDS-1:0] : {NUM_WORDS{1'b0}};
   assign irqStat_d  = (irqStat_q & ~irqClrMask) | wordEvent;

   // Summary interrupt registers; any event in word k sets sticky bit k.
   always @(posedge clk)
   begin
      if (srst)
      begin
         irqStat_q <= `IFEB_RST_IRQ;
         irqEn_q   <= `IFEB_RST_IRQ;
      end
      else
      begin
         irqStat_q <= irqStat_d;
         if (irqEnWr)
         begin
            irqEn_q <= pwdata[NUM_WORDS-1:0];
         end
      end
   end

   // Level interrupt: it stays high until software clears or masks every enabled status bit.
   assign irqOut = |(irqStat_q & irqEn_q);

   // Read mux and unmapped-address detection. The clear word is write-only and
   // reads zero. Read data is zero outside the access phase so that an idle bus
   // never shows register contents.
   integer i;
   always @*
   begin
      prdata  = 32'h0000_0000;
      pslverr = 1'b0;
      if (accessPhase)
      begin
         pslverr = ~addrHit;
         for (i = 0; i < NUM_WORDS; i = i + 1)
         begin
            if (selFlag[i])
            begin
               prdata = {16'h0000, flagVec[i*16 +: 16]};
            end
            if (selEn[i])
            begin
               prdata = {16'h0000, enVec[i*16 +: 16]};
            end
         end
         if (selIrqStat)
         begin
            prdata[NUM_WORDS-1:0] = irqStat_q;
         end
         if (selIrqEn)
         begin
            prdata[NUM_WORDS-1:0] = irqEn_q;
         end
      end
   end

endmodule // ifeb_bank

//--- hw/ifeb_map.vh
// Register map constants for the interrupt flag and enable bank.
// Assumes an APB slave with 32-bit data and word-aligned byte addresses.
`ifndef IFEB_MAP_VH
`define IFEB_MAP_VH

// Byte offsets: five flag words, then five enable words, then the summary interrupt group.
`define IFEB_OFF_FLAG_BASE 12'h000
`define IFEB_OFF_EN_BASE   12'h014
`define IFEB_OFF_IRQ_STAT  12'h028
`define IFEB_OFF_IRQ_CLR   12'h02c
`define IFEB_OFF_IRQ_EN    12'h030

// Implemented-bit masks per register index; flag and enable words share one layout.
`define IFEB_MASK_0 16'h3fef
`define IFEB_MASK_1 16'hfe1f
`define IFEB_MASK_2 16'h22e3
`define IFEB_MASK_3 16'h4006
`define IFEB_MASK_4 16'h010e

// Named field positions.
`define IFEB_BIT_LOW_VOLTAGE  8
`define IFEB_BIT_CRC_GEN      3
`define IFEB_BIT_UART_B_ERROR 2
`define IFEB_BIT_UART_A_ERROR 1
`define IFEB_BIT_UART_B_TX    15
`define IFEB_BIT_UART_B_RX    14

// Reset values.
`define IFEB_RST_WORD 16'h0000
`define IFEB_RST_IRQ  5'h00

`endif

//--- tb/ifeb_bank_sva.sv
// Checker for the flag and enable bank ports.
// Assumes the ifeb_map.vh map and a zero-wait APB slave.
`timescale 1ns/1ns
module ifeb_sva #(parameter NUM_WORDS = 5, parameter ADDR_W = 12) (
   input wire logic                    clk,
   input wire logic                    srst,
   input wire logic [ADDR_W-1:0]       paddr,
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [31:0]             prdata,
   input wire logic                    pready,
   input wire logic                    pslverr,
   input wire logic [NUM_WORDS*16-1:0] prioNonZero,
   input wire logic [NUM_WORDS*16-1:0] srcRequest,
   input wire logic                    irqOut
);
   // Only a write access may lower a flag, an enable or the interrupt.
   wire wrAcc = psel & penable & pwrite;
   wire rdAcc = psel & penable & !pwrite;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // Read phase of flag word four.
   sequence s_rdWord4;
      rdAcc && paddr == 12'h010;
   endsequence
   a_ready_high: assert property (pready) else $error("pready low");
   a_req_gated: assert property ((srcRequest & ~prioNonZero) == 0) else $error("ungated request");
   a_reset_clear: assert property ($fell(srst) |-> srcRequest == 0 && !irqOut) else $error("dirty reset");
   a_unmap_err: assert property (psel && penable && paddr > 12'h030 |-> pslverr && (pwrite || prdata == 0))
      else $error("unmapped access");
   a_word4_bits: assert property (s_rdWord4 |-> (prdata & ~32'h010e) == 0) else $error("stray bit");
   a_req_sticky: assert property (!wrAcc |=> ($past(srcRequest) & prioNonZero & ~srcRequest) == 0)
      else $error("request dropped");
   a_irq_sticky: assert property (irqOut && !wrAcc |=> irqOut) else $error("interrupt dropped");
   a_idle_quiet: assert property (!(psel && penable) |-> prdata == 0 && !pslverr) else $error("idle data");
endmodule // ifeb_sva
bind ifeb_bank ifeb_sva #(.NUM_WORDS(NUM_WORDS), .ADDR_W(ADDR_W)) chk (.clk, .srst, .paddr, .psel, .penable,
   .pwrite, .prdata, .pready, .pslverr, .prioNonZero, .srcRequest, .irqOut);

//--- tb/ifeb_bank_tb.sv
// Testbench: drives the bank over APB and pulses events.
// Assumes flag words at 0x00, enables at 0x14, interrupt group at 0x28.
`timescale 1ns/1ns
module ifeb_bank_tb;
   logic        clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0;
   logic [79:0] srcEvent = 0, prioNonZero = '1;
   wire  [31:0] prdata;
   wire  [79:0] srcRequest;
   wire         pready, pslverr, irqOut;
   int          mismatches = 0, cmp_count = 0, cyc = 0, k;
   logic [15:0] m [5] = '{16'h3fef, 16'hfe1f, 16'h22e3, 16'h4006, 16'h010e};
   ifeb_bank DUT (.clk, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
      .srcEvent, .prioNonZero, .srcRequest, .irqOut);
   // Free-running 50 MHz clock.
   initial forever #10 clk = ~clk;
   // Counts each comparison and reports a mismatch at once.
   task chk(string nm, logic [79:0] e, logic [79:0] g);
      cmp_count++;
      if (g !== e)
      begin
         mismatches++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask
   // One transfer; an idle cycle first keeps drivers from clashing.
   task apb(logic w, logic [11:0] a, logic [31:0] d, logic [31:0] e = 0);
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      chk("pslverr", (a > 12'h030) || (a[1:0] != 2'b00), pslverr);
      if (!w)
         chk("prdata", e, prdata);
      psel <= 0;
      penable <= 0;
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Hang guard; the tests need under two hundred cycles.
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         mismatches++;
         end_sim;
      end
   end
   // Register map, then events, requests and the interrupt.
   initial
   begin
      repeat (2) @(posedge clk);
      srst <= 0;
      for (k = 0; k < 13; k++)
         apb(0, 4 * k, 0, 0);
      for (k = 0; k < 10; k++)
         apb(1, 4 * k, 32'hffffffff);
      for (k = 0; k < 10; k++)
         apb(0, 4 * k, 0, m[k % 5]);
      for (k = 0; k < 10; k++)
         apb(1, 4 * k, 0);
      apb(1, 12'h02c, 32'h1f);
      $display("test map done");
      @(posedge clk) srcEvent <= {16'hffff, 64'h0};
      @(posedge clk) srcEvent <= 0;
      apb(0, 12'h010, 0, 32'h010e);
      apb(1, 12'h024, 32'hffff);
      @(negedge clk) chk("srcRequest", {16'h010e, 64'h0}, srcRequest);
      @(posedge clk) prioNonZero <= 0;
      @(negedge clk) chk("srcRequest", 0, srcRequest);
      @(posedge clk) prioNonZero <= '1;
      apb(1, 12'h024, 32'h0008);
      @(negedge clk) chk("srcRequest", {16'h0008, 64'h0}, srcRequest);
      $display("test requests done");
      chk("irqOut", 0, irqOut);
      apb(1, 12'h030, 32'h10);
      apb(0, 12'h028, 0, 32'h10);
      @(negedge clk) chk("irqOut", 1, irqOut);
      apb(1, 12'h02c, 32'h10);
      @(negedge clk) chk("irqOut", 0, irqOut);
      apb(0, 12'h034, 0, 0);
      $display("test interrupt done");
      apb(1, 12'h014, 32'hffff);
      @(posedge clk) srcEvent <= 80'h1;
      @(posedge clk) srcEvent <= 0;
      apb(0, 12'h000, 0, 32'h1);
      @(posedge clk) srst <= 1;
      repeat (2) @(posedge clk);
      srst <= 0;
      apb(0, 12'h000, 0, 0);
      apb(0, 12'h014, 0, 0);
      apb(0, 12'h030, 0, 0);
      @(negedge clk) chk("srcRequest", 0, srcRequest);
      $display("test reset done");
      end_sim;
   end
endmodule // ifeb_bank_tb
